// File: ssc_addr_window.sv
// power-up window during which a broadcast may store the link address
`include "ssc_regs.svh"
module ssc_addr_window #(
   parameter logic [35:0] WIN_CYCLES = `SSC_WIN_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic close_req,
   output logic      open_ff
);
   import ssc_pkg::*;

   logic [35:0] cnt_ff;

   // counts from power-up; closed by expiry or a stored address
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff  <= 36'h0;
         open_ff <= 1'b1;
      end else if (open_ff) begin
         cnt_ff <= cnt_ff + 36'h1;
         if (close_req || cnt_ff == WIN_CYCLES - 36'h1) begin
            open_ff <= 1'b0;
         end
      end
   end

   property p_stays_closed;
      @(posedge clk) disable iff (rst) !open_ff |=> !open_ff;
   endproperty
   a_stays_closed: assert property (p_stays_closed)
      else $error("address window reopened without power cycle");

   property p_expiry_closes;
      @(posedge clk) disable iff (rst) open_ff && cnt_ff == WIN_CYCLES - 36'h1 |=> !open_ff;
   endproperty
   a_expiry_closes: assert property (p_expiry_closes)
      else $error("address window still open after expiry");
endmodule

// File: ssc_cmd_remap.sv
// serial slave command interpreter, address store and user register map
// Functional notes
// - commands via coil write or multi-register write
// - command block at 1160, 1161, 1162
// - operation 1 triggers reset action
// - link address OFF at factory, restore
// - default link 9600 baud, no parity
// - address store only in first 2 minutes
// - after store or expiry, refuse changes
// - store answered by echo with address 00
// - any register remappable into user area
// - 120-entry index table at 1280h-12F7h
// - 0100h-0177h reads register named by index
// - entry n governs data slot 0100h plus n
// - index writes by single or multi write
// - index table kept in nonvolatile storage
// - CRC-failed frames dropped without reply
// - errors answer function plus 128, code
// - words are 16 bits, high byte first
`include "ssc_regs.svh"
module ssc_cmd_remap #(
   parameter logic [35:0] WIN_CYCLES = `SSC_WIN_CYCLES
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                req_valid,
   input  wire logic                req_crc_ok,
   input  wire logic [7:0]          req_slave,
   input  wire logic [7:0]          req_func,
   input  wire logic [15:0]         req_start,
   input  wire logic [15:0]         req_qty,
   input  wire logic                wdat_valid,
   input  wire logic [15:0]         wdat,
   input  wire logic                src_ack,
   input  wire logic [15:0]         src_data,
   input  wire logic                nv_load_valid,
   input  wire logic [6:0]          nv_load_idx,
   input  wire logic [15:0]         nv_load_data,
   input  wire logic                restore_defaults,
   output logic                     req_ready_ff,
   output logic                     rsp_valid_ff,
   output logic [7:0]               rsp_slave_ff,
   output logic [7:0]               rsp_func_ff,
   output ssc_pkg::ssc_exc_type     rsp_exc_ff,
   output logic [15:0]              rsp_start_ff,
   output logic [15:0]              rsp_qty_ff,
   output logic                     rd_valid_ff,
   output logic [15:0]              rd_word_ff,
   output logic                     src_req_ff,
   output logic [15:0]              src_addr_ff,
   output logic                     nv_wr_ff,
   output logic [6:0]               nv_wr_idx_ff,
   output logic [15:0]              nv_wr_data_ff,
   output logic                     cmd_reset_ff,
   output logic [7:0]               link_addr_ff,
   output logic [15:0]              link_baud_ff,
   output logic [1:0]               link_parity_ff,
   output logic                     win_open_ff
);
   import ssc_pkg::*;

   ssc_state_type st_ff;
   ssc_state_type nxt_st;
   ssc_area_type  area_ff;
   ssc_area_type  nxt_area;
   ssc_exc_type   exc_ff;
   ssc_exc_type   nxt_exc;
   ssc_exc_type   exec_exc;
   logic [15:0]   tbl [0:119];
   logic [7:0]    slave_ff;
   logic [7:0]    func_ff;
   logic [15:0]   start_ff;
   logic [15:0]   qty_ff;
   logic [15:0]   last_word_ff;
   logic [6:0]    cnt_ff;
   logic          bcast_ff;
   logic          stored_ff;
   logic [15:0]   cmd_fn_ff;
   logic [15:0]   cmd_op_ff;
   logic [15:0]   cmd_dat_ff;
   logic [16:0]   req_end;
   logic          addressed;
   logic          is_read;
   logic [6:0]    tbl_idx;
   logic [15:0]   cmd_addr;
   logic [15:0]   cmd_word;
   logic          tbl_we;
   logic          last_cnt;
   logic          is_cmd;
   logic [15:0]   op_num;
   logic          do_reset;
   logic          do_store;

   ssc_addr_window #(
      .WIN_CYCLES (WIN_CYCLES)
   ) u_window (
      .clk       (clk),
      .rst       (rst),
      .close_req (do_store),
      .open_ff   (win_open_ff)
   );

   // request decode
   assign req_end   = {1'b0, req_start} + {1'b0, req_qty};
   assign addressed = (req_slave == `SSC_BCAST) ||
                      (link_addr_ff != `SSC_LINK_OFF && req_slave == link_addr_ff);
   assign is_read   = (req_func == `SSC_FN_READ_HOLD) || (req_func == `SSC_FN_READ_INPUT);

   always_comb begin
      nxt_area = AREA_NONE;
      if (req_start >= `SSC_ADDR_MAP_DATA &&
          req_end <= {1'b0, `SSC_ADDR_MAP_DATA} + {1'b0, `SSC_MAP_LEN}) begin
         nxt_area = AREA_DATA;
      end else if (req_start >= `SSC_ADDR_MAP_IDX &&
                   req_end <= {1'b0, `SSC_ADDR_MAP_IDX} + {1'b0, `SSC_MAP_LEN}) begin
         nxt_area = AREA_INDEX;
      end else if (req_start >= `SSC_ADDR_CMD_FUNC &&
                   req_end <= {1'b0, `SSC_ADDR_CMD_FUNC} + {1'b0, `SSC_CMD_LEN}) begin
         nxt_area = AREA_CMD;
      end
   end

   // exception decided when the frame is taken
   always_comb begin
      nxt_exc = EXC_NONE;
      case (req_func)
         `SSC_FN_READ_HOLD, `SSC_FN_READ_INPUT, `SSC_FN_WR_MULTI: begin
            if (req_qty == 16'h0 || req_qty > `SSC_MAP_LEN) begin
               nxt_exc = EXC_VALUE;
            end else if (nxt_area == AREA_NONE ||
                         (!is_read && nxt_area == AREA_DATA)) begin
               nxt_exc = EXC_ADDR;
            end
         end
         `SSC_FN_WR_SINGLE: begin
            if (nxt_area != AREA_INDEX && nxt_area != AREA_CMD) begin
               nxt_exc = EXC_ADDR;
            end
         end
         `SSC_FN_WR_COIL: begin
            nxt_exc = EXC_NONE;
         end
         default: begin
            nxt_exc = EXC_FUNC;
         end
      endcase
   end

   // word position within the selected area
   assign tbl_idx  = (area_ff == AREA_DATA) ? 7'(start_ff - `SSC_ADDR_MAP_DATA) + cnt_ff
                                            : 7'(start_ff - `SSC_ADDR_MAP_IDX) + cnt_ff;
   assign cmd_addr = start_ff + {9'h0, cnt_ff};
   assign last_cnt = ({9'h0, cnt_ff} + 16'h1 >= qty_ff);
   assign tbl_we   = (st_ff == ST_COLLECT) && wdat_valid && exc_ff == EXC_NONE &&
                     area_ff == AREA_INDEX;

   always_comb begin
      case (cmd_addr)
         `SSC_ADDR_CMD_FUNC: cmd_word = cmd_fn_ff;
         `SSC_ADDR_CMD_OP:   cmd_word = cmd_op_ff;
         default:            cmd_word = cmd_dat_ff;
      endcase
   end

   // index table, one entry per slot; writes mirrored to setpoint storage
   generate
      for (genvar g = 0; g < 120; g++) begin : g_tbl
         always_ff @(posedge clk) begin
            if (tbl_we && tbl_idx == 7'(g)) begin
               tbl[g] <= wdat;
            end else if (nv_load_valid && nv_load_idx == 7'(g)) begin
               tbl[g] <= nv_load_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         nv_wr_ff      <= 1'b0;
         nv_wr_idx_ff  <= 7'h0;
         nv_wr_data_ff <= 16'h0;
      end else begin
         nv_wr_ff <= tbl_we;
         if (tbl_we) begin
            nv_wr_idx_ff  <= tbl_idx;
            nv_wr_data_ff <= wdat;
         end
      end
   end

   // command evaluation
   assign is_cmd = (func_ff == `SSC_FN_WR_COIL) ||
                   (func_ff == `SSC_FN_WR_MULTI && area_ff == AREA_CMD &&
                    start_ff == `SSC_ADDR_CMD_FUNC && qty_ff >= 16'h2);
   assign op_num = (func_ff == `SSC_FN_WR_COIL) ? start_ff : cmd_op_ff;

   always_comb begin
      exec_exc = EXC_NONE;
      do_reset = 1'b0;
      do_store = 1'b0;
      if (st_ff == ST_EXEC && exc_ff == EXC_NONE && is_cmd) begin
         if (func_ff == `SSC_FN_WR_MULTI && cmd_fn_ff != `SSC_CMD_SELECT) begin
            exec_exc = EXC_VALUE;
         end else if (op_num == `SSC_OP_RESET) begin
            do_reset = 1'b1;
         end else if (op_num == `SSC_OP_STORE_ADDR && bcast_ff && qty_ff == 16'h3 &&
                      func_ff == `SSC_FN_WR_MULTI) begin
            if (cmd_dat_ff[15:8] != 8'h0 || cmd_dat_ff[7:0] == `SSC_BCAST) begin
               exec_exc = EXC_VALUE;
            end else if (win_open_ff) begin
               do_store = 1'b1;
            end
         end else begin
            exec_exc = EXC_VALUE;
         end
      end
   end

   // link settings
   always_ff @(posedge clk) begin
      if (rst) begin
         link_addr_ff   <= `SSC_LINK_OFF;
         link_baud_ff   <= `SSC_BAUD_DEF;
         link_parity_ff <= `SSC_PARITY_NONE;
      end else if (restore_defaults) begin
         link_addr_ff <= `SSC_LINK_OFF;
      end else if (do_store) begin
         link_addr_ff <= cmd_dat_ff[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_reset_ff <= 1'b0;
      end else begin
         cmd_reset_ff <= do_reset;
      end
   end

   // sequencer
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (req_valid && req_crc_ok && addressed) begin
               if (nxt_exc == EXC_FUNC) begin
                  nxt_st = ST_RESP;
               end else if (is_read) begin
                  nxt_st = (nxt_exc == EXC_NONE) ? ST_FETCH : ST_RESP;
               end else begin
                  nxt_st = ST_COLLECT;
               end
            end
         end
         ST_COLLECT: if (wdat_valid && last_cnt) begin
            nxt_st = ST_EXEC;
         end
         ST_EXEC:  nxt_st = ST_RESP;
         ST_FETCH: begin
            if (area_ff == AREA_DATA) begin
               nxt_st = ST_WAIT;
            end else if (last_cnt) begin
               nxt_st = ST_RESP;
            end
         end
         ST_WAIT: if (src_ack) begin
            nxt_st = last_cnt ? ST_RESP : ST_FETCH;
         end
         ST_RESP:  nxt_st = ST_IDLE;
         default:  nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff        <= ST_IDLE;
         req_ready_ff <= 1'b1;
      end else begin
         st_ff        <= nxt_st;
         req_ready_ff <= (nxt_st == ST_IDLE);
      end
   end

   // frame fields and progress
   always_ff @(posedge clk) begin
      if (rst) begin
         slave_ff     <= 8'h0;
         func_ff      <= 8'h0;
         start_ff     <= 16'h0;
         qty_ff       <= 16'h0;
         area_ff      <= AREA_NONE;
         exc_ff       <= EXC_NONE;
         bcast_ff     <= 1'b0;
         stored_ff    <= 1'b0;
         cnt_ff       <= 7'h0;
         last_word_ff <= 16'h0;
      end else begin
         if (st_ff == ST_IDLE && nxt_st != ST_IDLE) begin
            slave_ff  <= req_slave;
            func_ff   <= req_func;
            start_ff  <= req_start;
            qty_ff    <= (req_func == `SSC_FN_WR_COIL || req_func == `SSC_FN_WR_SINGLE) ?
                         16'h1 : req_qty;
            area_ff   <= (req_func == `SSC_FN_WR_COIL) ? AREA_CMD : nxt_area;
            exc_ff    <= nxt_exc;
            bcast_ff  <= (req_slave == `SSC_BCAST);
            stored_ff <= 1'b0;
            cnt_ff    <= 7'h0;
         end else if (st_ff == ST_COLLECT && wdat_valid) begin
            cnt_ff       <= cnt_ff + 7'h1;
            last_word_ff <= wdat;
         end else if (st_ff == ST_EXEC) begin
            if (exec_exc != EXC_NONE) begin
               exc_ff <= exec_exc;
            end
            stored_ff <= do_store;
         end else if ((st_ff == ST_FETCH && area_ff != AREA_DATA) ||
                      (st_ff == ST_WAIT && src_ack)) begin
            cnt_ff <= cnt_ff + 7'h1;
         end
      end
   end

   // command block registers, written word by word
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_fn_ff  <= 16'h0;
         cmd_op_ff  <= 16'h0;
         cmd_dat_ff <= 16'h0;
      end else if (st_ff == ST_COLLECT && wdat_valid && exc_ff == EXC_NONE &&
                   area_ff == AREA_CMD && func_ff != `SSC_FN_WR_COIL) begin
         case (cmd_addr)
            `SSC_ADDR_CMD_FUNC: cmd_fn_ff  <= wdat;
            `SSC_ADDR_CMD_OP:   cmd_op_ff  <= wdat;
            default:            cmd_dat_ff <= wdat;
         endcase
      end
   end

   // read path: user data slots fetch the register named by their entry
   always_ff @(posedge clk) begin
      if (rst) begin
         src_req_ff  <= 1'b0;
         src_addr_ff <= 16'h0;
         rd_valid_ff <= 1'b0;
         rd_word_ff  <= 16'h0;
      end else begin
         src_req_ff  <= 1'b0;
         rd_valid_ff <= 1'b0;
         if (st_ff == ST_FETCH && area_ff == AREA_DATA) begin
            src_req_ff  <= 1'b1;
            src_addr_ff <= tbl[tbl_idx];
         end else if (st_ff == ST_FETCH) begin
            rd_valid_ff <= 1'b1;
            rd_word_ff  <= (area_ff == AREA_INDEX) ? tbl[tbl_idx] : cmd_word;
         end else if (st_ff == ST_WAIT && src_ack) begin
            rd_valid_ff <= 1'b1;
            rd_word_ff  <= src_data;
         end
      end
   end

   // answer; broadcasts answer only a stored address
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_valid_ff <= 1'b0;
         rsp_slave_ff <= 8'h0;
         rsp_func_ff  <= 8'h0;
         rsp_exc_ff   <= EXC_NONE;
         rsp_start_ff <= 16'h0;
         rsp_qty_ff   <= 16'h0;
      end else begin
         rsp_valid_ff <= 1'b0;
         if (st_ff == ST_RESP && (!bcast_ff || stored_ff)) begin
            rsp_valid_ff <= 1'b1;
            rsp_slave_ff <= slave_ff;
            rsp_exc_ff   <= exc_ff;
            rsp_func_ff  <= (exc_ff != EXC_NONE) ? (func_ff | `SSC_FN_EXC_FLAG) : func_ff;
            rsp_start_ff <= start_ff;
            rsp_qty_ff   <= (func_ff == `SSC_FN_WR_MULTI || func_ff == `SSC_FN_READ_HOLD ||
                             func_ff == `SSC_FN_READ_INPUT) ? qty_ff : last_word_ff;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_crc_drop;
      st_ff == ST_IDLE && req_valid && !req_crc_ok |=> st_ff == ST_IDLE ##1 !rsp_valid_ff;
   endproperty
   a_crc_drop: assert property (p_crc_drop)
      else $error("frame with bad CRC was processed");

   property p_reset_op;
      st_ff == ST_EXEC && exc_ff == EXC_NONE && func_ff == `SSC_FN_WR_MULTI && is_cmd && !bcast_ff &&
      cmd_fn_ff == `SSC_CMD_SELECT && cmd_op_ff == `SSC_OP_RESET |=> cmd_reset_ff ##1 rsp_valid_ff;
   endproperty
   a_reset_op: assert property (p_reset_op)
      else $error("reset command did not pulse reset action");

   property p_store_in_window;
      !$past(restore_defaults) && link_addr_ff != $past(link_addr_ff) |-> $past(win_open_ff);
   endproperty
   a_store_in_window: assert property (p_store_in_window)
      else $error("link address changed outside power-up window");

   property p_closed_after_store;
      do_store |=> !win_open_ff [*3];
   endproperty
   a_closed_after_store: assert property (p_closed_after_store)
      else $error("window still open after address store");

   property p_bcast_echo;
      rsp_valid_ff && rsp_slave_ff == `SSC_BCAST |->
         rsp_func_ff == `SSC_FN_WR_MULTI && rsp_exc_ff == EXC_NONE && rsp_qty_ff == 16'h3;
   endproperty
   a_bcast_echo: assert property (p_bcast_echo)
      else $error("broadcast answer is not a store echo");

   property p_exc_flag;
      rsp_valid_ff |-> (rsp_exc_ff != EXC_NONE) == rsp_func_ff[7];
   endproperty
   a_exc_flag: assert property (p_exc_flag)
      else $error("exception answer lacks function flag");

   property p_restore_off;
      restore_defaults |=> link_addr_ff == `SSC_LINK_OFF;
   endproperty
   a_restore_off: assert property (p_restore_off)
      else $error("restore did not disable link address");

   property p_link_default;
      link_baud_ff == `SSC_BAUD_DEF && link_parity_ff == `SSC_PARITY_NONE;
   endproperty
   a_link_default: assert property (p_link_default)
      else $error("link settings moved from default");

   property p_nv_mirror;
      tbl_we |=> nv_wr_ff && nv_wr_data_ff == $past(wdat);
   endproperty
   a_nv_mirror: assert property (p_nv_mirror)
      else $error("index write not mirrored to setpoint store");

   property p_fetch_data;
      st_ff == ST_WAIT && src_ack |=> rd_valid_ff && rd_word_ff == $past(src_data);
   endproperty
   a_fetch_data: assert property (p_fetch_data)
      else $error("fetched register not returned");

   property p_bad_select;
      st_ff == ST_EXEC && exc_ff == EXC_NONE && is_cmd && func_ff == `SSC_FN_WR_MULTI &&
      cmd_fn_ff != `SSC_CMD_SELECT && !bcast_ff |=> ##1 rsp_valid_ff && rsp_exc_ff == EXC_VALUE;
   endproperty
   a_bad_select: assert property (p_bad_select)
      else $error("wrong function select not refused");

   c_reset_cmd:  cover property (cmd_reset_ff);
   c_addr_store: cover property (do_store ##2 rsp_valid_ff);
   c_map_read:   cover property (src_req_ff ##[1:8] rd_valid_ff);
   c_exception:  cover property (rsp_valid_ff && rsp_exc_ff == EXC_ADDR);
endmodule

// File: ssc_pkg.sv
// types shared by the serial command block
package ssc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_COLLECT = 3'b001,
      ST_EXEC    = 3'b010,
      ST_FETCH   = 3'b011,
      ST_WAIT    = 3'b100,
      ST_RESP    = 3'b101
   } ssc_state_type;

   typedef enum logic [7:0] {
      EXC_NONE  = 8'h00,
      EXC_FUNC  = 8'h01,
      EXC_ADDR  = 8'h02,
      EXC_VALUE = 8'h03
   } ssc_exc_type;

   typedef enum logic [1:0] {
      AREA_NONE  = 2'b00,
      AREA_DATA  = 2'b01,
      AREA_INDEX = 2'b10,
      AREA_CMD   = 2'b11
   } ssc_area_type;
endpackage

// File: ssc_regs.svh
// register addresses, field values and timing counts of the serial command block
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// function codes
`define SSC_FN_READ_HOLD  8'h03
`define SSC_FN_READ_INPUT 8'h04
`define SSC_FN_WR_COIL    8'h05
`define SSC_FN_WR_SINGLE  8'h06
`define SSC_FN_WR_MULTI   8'h10
`define SSC_FN_EXC_FLAG   8'h80

// register map
`define SSC_ADDR_MAP_DATA 16'h0100
`define SSC_ADDR_MAP_IDX  16'h1280
`define SSC_MAP_LEN       16'h0078
`define SSC_ADDR_CMD_FUNC 16'h1160
`define SSC_ADDR_CMD_OP   16'h1161
`define SSC_ADDR_CMD_DATA 16'h1162
`define SSC_CMD_LEN       16'h0003

// command block values
`define SSC_CMD_SELECT    16'h0005
`define SSC_OP_RESET      16'h0001
`define SSC_OP_STORE_ADDR 16'h0010

// link settings
`define SSC_BCAST         8'h00
`define SSC_LINK_OFF      8'h00
`define SSC_BAUD_DEF      16'h2580
`define SSC_PARITY_NONE   2'h0

// power-up address window
`define SSC_CLK_HZ        64'd100000000
`define SSC_WIN_MIN       64'd2
`define SSC_WIN_CYCLES    (36'(`SSC_WIN_MIN * 64'd60 * `SSC_CLK_HZ))

`endif

// File: ssc_src_model.sv
// register store that answers index fetches, promptly and slowly in turn
module ssc_src_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        src_req,
   input  wire logic [15:0] src_addr,
   output logic             src_ack,
   output logic [15:0]      src_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] addr_ff;
   logic [2:0]  wait_ff;
   logic        busy_ff;
   logic        slow_ff;
   always_ff @(posedge clk) begin
      src_ack  <= 1'b0;
      src_data <= ~src_data;
      if (rst) begin
         busy_ff  <= 1'b0;
         slow_ff  <= 1'b0;
         src_data <= 16'h0000;
      end else if (src_req) begin
         busy_ff <= 1'b1;
         addr_ff <= src_addr;
         wait_ff <= slow_ff ? 3'h3 : 3'h0;
         slow_ff <= ~slow_ff;
      end else if (busy_ff && wait_ff == 3'h0) begin
         busy_ff  <= 1'b0;
         src_ack  <= 1'b1;
         src_data <= addr_ff ^ 16'hA5C3;
      end else if (busy_ff) begin
         wait_ff <= wait_ff - 3'h1;
      end
   end
endmodule

// File: testbench.sv
// self-checking bench of the serial command block
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0]  fn;
      logic [15:0] st;
      logic [15:0] qt;
      logic [1:0]  nw;
      logic [15:0] w0;
      logic [15:0] w1;
      logic [7:0]  efn;
      logic [7:0]  exc;
      logic        cr;
   } ssc_row_type;
   logic        clk, rst, req_valid, req_crc_ok, wdat_valid, src_ack, nv_load_valid, restore_defaults;
   logic [7:0]  req_slave, req_func;
   logic [15:0] req_start, req_qty, wdat, src_data, nv_load_data;
   logic [6:0]  nv_load_idx;
   logic        req_ready_ff, rsp_valid_ff, rd_valid_ff, src_req_ff, nv_wr_ff, cmd_reset_ff, win_open_ff;
   logic [7:0]  rsp_slave_ff, rsp_func_ff, link_addr_ff;
   logic [15:0] rsp_start_ff, rsp_qty_ff, rd_word_ff, src_addr_ff, nv_wr_data_ff, link_baud_ff;
   logic [6:0]  nv_wr_idx_ff;
   logic [1:0]  link_parity_ff;
   ssc_pkg::ssc_exc_type rsp_exc_ff;
   logic [15:0] wq [4];
   logic [15:0] rdq [$];
   logic [22:0] nv_last;
   logic        got;
   int          err_total, num_checks, n_reset, n0, cyc;
   ssc_row_type rows [10] = '{
      '{8'h06, 16'h1280, 16'h1, 2'd1, 16'h0031, 16'h0, 8'h06, 8'h00, 1'b0},
      '{8'h10, 16'h1281, 16'h1, 2'd1, 16'h0023, 16'h0, 8'h10, 8'h00, 1'b0},
      '{8'h10, 16'h12F6, 16'h2, 2'd2, 16'h0050, 16'h0011, 8'h10, 8'h00, 1'b0},
      '{8'h10, 16'h12F7, 16'h2, 2'd2, 16'h0001, 16'h0002, 8'h90, 8'h02, 1'b0},
      '{8'h10, 16'h1160, 16'h2, 2'd2, 16'h0005, 16'h0001, 8'h10, 8'h00, 1'b1},
      '{8'h05, 16'h0001, 16'h1, 2'd1, 16'hFF00, 16'h0, 8'h05, 8'h00, 1'b1},
      '{8'h10, 16'h1160, 16'h2, 2'd2, 16'h0004, 16'h0001, 8'h90, 8'h03, 1'b0},
      '{8'h10, 16'h1160, 16'h2, 2'd2, 16'h0005, 16'h0010, 8'h90, 8'h03, 1'b0},
      '{8'h03, 16'h0100, 16'h0, 2'd0, 16'h0, 16'h0, 8'h83, 8'h03, 1'b0},
      '{8'h07, 16'h0000, 16'h1, 2'd0, 16'h0, 16'h0, 8'h87, 8'h01, 1'b0}};
   ssc_cmd_remap #(.WIN_CYCLES(36'd200)) ssc_cmd_remap_inst (
      .clk, .rst, .req_valid, .req_crc_ok, .req_slave, .req_func, .req_start, .req_qty, .wdat_valid, .wdat,
      .src_ack, .src_data, .nv_load_valid, .nv_load_idx, .nv_load_data, .restore_defaults, .req_ready_ff,
      .rsp_valid_ff, .rsp_slave_ff, .rsp_func_ff, .rsp_exc_ff, .rsp_start_ff, .rsp_qty_ff, .rd_valid_ff,
      .rd_word_ff, .src_req_ff, .src_addr_ff, .nv_wr_ff, .nv_wr_idx_ff, .nv_wr_data_ff, .cmd_reset_ff,
      .link_addr_ff, .link_baud_ff, .link_parity_ff, .win_open_ff);
   ssc_src_model ssc_src_model_inst (.clk, .rst, .src_req(src_req_ff), .src_addr(src_addr_ff), .src_ack, .src_data);
   function automatic logic [15:0] fv(input logic [15:0] a);
      return a ^ 16'hA5C3;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   // one frame, then up to 40 cycles for its answer
   task automatic xfer(input logic [7:0] sl, fn, input logic [15:0] st, qt, input int nw);
      got = 1'b0;
      do @(posedge clk); while (req_ready_ff !== 1'b1);
      req_valid <= 1'b1;
      req_slave <= sl;
      req_func  <= fn;
      req_start <= st;
      req_qty   <= qt;
      @(posedge clk);
      req_valid <= 1'b0;
      for (int i = 0; i < nw; i++) begin
         wdat_valid <= 1'b1;
         wdat       <= wq[i];
         @(posedge clk);
      end
      wdat_valid <= 1'b0;
      for (int k = 0; k < 40 && got !== 1'b1; k++) begin
         @(posedge clk);
         got = rsp_valid_ff;
      end
   endtask
   task automatic rd_chk(input logic [7:0] fn, input logic [15:0] st, qt, e0, e1);
      rdq = {};
      xfer(8'h25, fn, st, qt, 0);
      `CHK(got, 1'b1);
      `CHK(rdq.size(), qt);
      `CHK(rdq[0], e0);
      if (qt > 1) `CHK(rdq[1], e1);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (rd_valid_ff === 1'b1) rdq.push_back(rd_word_ff);
      if (cmd_reset_ff === 1'b1) n_reset++;
      if (nv_wr_ff === 1'b1) nv_last = {nv_wr_idx_ff, nv_wr_data_ff};
      if (cyc == 5000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      {req_valid, wdat_valid, nv_load_valid, restore_defaults} = 4'h0;
      {req_slave, req_func, req_start, req_qty, wdat, nv_load_idx, nv_load_data} = '0;
      req_crc_ok = 1'b1;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK(link_addr_ff, 8'h00);
      `CHK({link_baud_ff, link_parity_ff}, {16'h2580, 2'h0});
      `CHK(win_open_ff, 1'b1);
      done("reset");
      wq = '{16'h0005, 16'h0010, 16'h0025, 16'h0};
      xfer(8'h00, 8'h10, 16'h1160, 16'h3, 3);
      `CHK({got, rsp_slave_ff, rsp_func_ff}, {1'b1, 16'h0010});
      `CHK({rsp_start_ff, rsp_qty_ff}, {16'h1160, 16'h3});
      `CHK({link_addr_ff, win_open_ff}, {8'h25, 1'b0});
      wq[2] = 16'h0033;
      xfer(8'h00, 8'h10, 16'h1160, 16'h3, 3);
      `CHK({got, link_addr_ff}, {1'b0, 8'h25});
      req_crc_ok <= 1'b0;
      xfer(8'h25, 8'h03, 16'h1280, 16'h1, 0);
      req_crc_ok <= 1'b1;
      `CHK(got, 1'b0);
      done("address store");
      foreach (rows[r]) begin
         wq[0] = rows[r].w0;
         wq[1] = rows[r].w1;
         n0 = n_reset;
         xfer(8'h25, rows[r].fn, rows[r].st, rows[r].qt, int'(rows[r].nw));
         `CHK({got, rsp_slave_ff, rsp_func_ff}, {1'b1, 8'h25, rows[r].efn});
         `CHK(rsp_exc_ff, rows[r].exc);
         `CHK(n_reset - n0, rows[r].cr);
      end
      `CHK(nv_last, {7'h77, 16'h0011});
      done("rows");
      rd_chk(8'h03, 16'h0100, 16'h2, fv(16'h0031), fv(16'h0023));
      rd_chk(8'h04, 16'h0176, 16'h2, fv(16'h0050), fv(16'h0011));
      rd_chk(8'h03, 16'h1280, 16'h1, 16'h0031, 16'h0);
      nv_load_valid <= 1'b1;
      nv_load_idx   <= 7'h02;
      nv_load_data  <= 16'h0044;
      @(posedge clk);
      nv_load_valid <= 1'b0;
      rd_chk(8'h03, 16'h0102, 16'h1, fv(16'h0044), 16'h0);
      done("remap reads");
      restore_defaults <= 1'b1;
      @(posedge clk);
      restore_defaults <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(link_addr_ff, 8'h00);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (210) @(posedge clk);
      `CHK(win_open_ff, 1'b0);
      xfer(8'h00, 8'h10, 16'h1160, 16'h3, 3);
      `CHK({got, link_addr_ff}, {1'b0, 8'h00});
      done("window expiry");
      final_report();
   end
endmodule
